// *** hdl/bwse_bus_cycle.sv ***
`timescale 1ns/100ps
`include "bwse_defines.svh"

// Summary of operation
// - wait input is sampled at the rising half of the access state.
// - a low sample adds one hold state while the strobe stays active.
// - each hold state repeats the access state and resamples wait.
// - wait held low keeps adding hold states without limit.
// - special I/O transfers always get one automatic hold state.
// - select output is low for memory and high for I/O references.
// - special I/O copies the 8-bit port onto both address halves.

module bwse_bus_cycle
   import bwse_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    req_valid,
   output logic                         req_ready,
   input  wire bwse_req_t               req,
   output bwse_rsp_t                    rsp,
   output logic [`BWSE_ADDR_W-1:0]      addr_q,
   output logic                         io_sel_q,
   output logic                         rd_n_q,
   output logic                         wr_n_q,
   input  wire logic                    wait_n,
   input  wire logic [`BWSE_DATA_W-1:0] data_i,
   output logic [`BWSE_DATA_W-1:0]      data_o_q,
   output logic                         data_oe_q
);

   bwse_state_t state_q;
   logic        ph_q;
   logic        write_q;
   logic        special_q;
   logic        force_q;
   logic        hold_q;
   logic        sample;
   logic        phase_end;
   logic        done_q;
   logic [`BWSE_DATA_W-1:0] rdata_q;

   // address for the request, port duplicated for special I/O
   function automatic logic [`BWSE_ADDR_W-1:0] bus_addr(input bwse_req_t r);
      if (r.is_io && r.special_io) begin
         bus_addr = {r.addr[`BWSE_PORT_W-1:0], r.addr[`BWSE_PORT_W-1:0]};
      end else begin
         bus_addr = r.addr;
      end
   endfunction

   // handshake and sample point
   assign req_ready = (state_q == BWSE_IDLE);
   assign phase_end = (ph_q == `BWSE_PH_FALL);
   assign sample    = (ph_q == `BWSE_PH_RISE) &&
                      (state_q == BWSE_ACCESS_STATE ||
                       state_q == BWSE_INSERTED_HOLD_STATE);
   assign rsp       = '{done: done_q, rdata: rdata_q}; // one driver for the whole struct

   bwse_wait_sampler u_wait (
      .clk        (clk),
      .srst       (srst),
      .sample     (sample),
      .force_hold (force_q),
      .wait_n     (wait_n),
      .hold_q     (hold_q)
   );

   // half-cycle phase within each T-state
   always_ff @(posedge clk) begin
      if (srst || state_q == BWSE_IDLE) begin
         ph_q <= `BWSE_PH_RISE;
      end else begin
         ph_q <= ~ph_q;
      end
   end

   // T-state sequencing
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= BWSE_IDLE;
      end else begin
         unique case (state_q)
            BWSE_IDLE: begin
               if (req_valid) begin
                  state_q <= BWSE_T1;
               end
            end
            BWSE_T1: begin
               if (phase_end) begin
                  state_q <= BWSE_ACCESS_STATE;
               end
            end
            BWSE_ACCESS_STATE, BWSE_INSERTED_HOLD_STATE: begin
               if (phase_end) begin
                  state_q <= hold_q ? BWSE_INSERTED_HOLD_STATE : BWSE_T3;
               end
            end
            BWSE_T3: begin
               if (phase_end) begin
                  state_q <= BWSE_IDLE;
               end
            end
         endcase
      end
   end

   // automatic hold for special I/O, used once at the access state
   always_ff @(posedge clk) begin
      if (srst) begin
         force_q <= 1'b0;
      end else if (state_q == BWSE_IDLE && req_valid) begin
         force_q <= req.is_io && req.special_io;
      end else if (sample) begin
         force_q <= 1'b0;
      end
   end

   // address and select latched for the whole cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_q    <= '0;
         io_sel_q  <= `BWSE_SEL_MEM;
         write_q   <= 1'b0;
         special_q <= 1'b0;
      end else if (state_q == BWSE_IDLE && req_valid) begin
         addr_q    <= bus_addr(req);
         io_sel_q  <= req.is_io ? `BWSE_SEL_IO : `BWSE_SEL_MEM;
         write_q   <= req.write;
         special_q <= req.is_io && req.special_io;
      end
   end

   // strobes: active from access state start to T3 rising half
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
      end else if (state_q == BWSE_T1 && phase_end) begin
         rd_n_q <= write_q;
         wr_n_q <= ~write_q;
      end else if (state_q == BWSE_T3 && !phase_end) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
      end
   end

   // write data drive from T1 falling half to end of cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         data_o_q  <= '0;
         data_oe_q <= 1'b0;
      end else if (state_q == BWSE_T1 && !phase_end) begin
         data_o_q  <= req.wdata;
         data_oe_q <= write_q;
      end else if (state_q == BWSE_T3 && phase_end) begin
         data_oe_q <= 1'b0;
      end
   end

   // read capture and completion pulse
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= '0;
         done_q  <= 1'b0;
      end else begin
         done_q <= (state_q == BWSE_T3) && phase_end;
         if (state_q == BWSE_T3 && !phase_end && !write_q) begin
            rdata_q <= data_i;
         end
      end
   end

   // checks
   property p_wait_low_holds;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_ACCESS_STATE && sample && !wait_n)
         |-> ##2 (state_q == BWSE_INSERTED_HOLD_STATE);
   endproperty
   a_wait_low_holds: assert property (p_wait_low_holds)
      else $error("no hold after low wait");

   property p_strobe_in_hold;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_INSERTED_HOLD_STATE) |-> (rd_n_q ^ wr_n_q) && $past(rd_n_q ^ wr_n_q);
   endproperty
   a_strobe_in_hold: assert property (p_strobe_in_hold) else $error("strobe idle in hold");

   property p_hold_release;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_INSERTED_HOLD_STATE && sample && wait_n && !force_q)
         |-> ##2 (state_q == BWSE_T3);
   endproperty
   a_hold_release: assert property (p_hold_release) else $error("hold not released");

   property p_hold_repeat;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_INSERTED_HOLD_STATE && sample && !wait_n)
         |-> ##1 (state_q == BWSE_INSERTED_HOLD_STATE) [*2];
   endproperty
   a_hold_repeat: assert property (p_hold_repeat) else $error("hold not repeated");

   property p_special_auto;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_ACCESS_STATE && sample && special_q)
         |-> ##2 (state_q == BWSE_INSERTED_HOLD_STATE);
   endproperty
   a_special_auto: assert property (p_special_auto) else $error("no automatic hold");

   logic req_io_q;

   // request kind copy for the select check
   always_ff @(posedge clk) begin
      if (srst) begin
         req_io_q <= 1'b0;
      end else if (state_q == BWSE_IDLE && req_valid) begin
         req_io_q <= req.is_io;
      end
   end

   property p_sel_level;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_IDLE && req_valid)
         |=> (io_sel_q == req_io_q) throughout (state_q != BWSE_IDLE) [*4];
   endproperty
   a_sel_level: assert property (p_sel_level) else $error("select level wrong");

   property p_port_dup;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_IDLE && req_valid && req.is_io && req.special_io)
         |=> (addr_q[15:8] == $past(req.addr[7:0])) && (addr_q[7:0] == $past(req.addr[7:0]));
   endproperty
   a_port_dup: assert property (p_port_dup) else $error("port not duplicated");

   property p_min_cycle;
      @(posedge clk) disable iff (srst)
      (state_q == BWSE_IDLE && req_valid) |=> !done_q [*6] ##1 (done_q || !req_ready);
   endproperty
   a_min_cycle: assert property (p_min_cycle) else $error("cycle too short");

   c_hold:    cover property (@(posedge clk) state_q == BWSE_INSERTED_HOLD_STATE);
   c_special: cover property (@(posedge clk) special_q && done_q);
   c_nowait:  cover property (@(posedge clk) (state_q == BWSE_ACCESS_STATE) ##2
                              (state_q == BWSE_T3));

endmodule

// *** hdl/bwse_defines.svh ***
`ifndef BWSE_DEFINES_SVH
`define BWSE_DEFINES_SVH

// bus widths
`define BWSE_ADDR_W     16
`define BWSE_PORT_W     8
`define BWSE_DATA_W     8

// select line levels
`define BWSE_SEL_MEM    1'b0
`define BWSE_SEL_IO     1'b1

// clock phases in one T-state: rising half then falling half
`define BWSE_PH_RISE    1'b0
`define BWSE_PH_FALL    1'b1

`endif

// *** hdl/bwse_pkg.sv ***
`include "bwse_defines.svh"

package bwse_pkg;

   // bus cycle states
   typedef enum logic [2:0] {
      BWSE_IDLE,
      BWSE_T1,
      BWSE_ACCESS_STATE,
      BWSE_INSERTED_HOLD_STATE,
      BWSE_T3
   } bwse_state_t;

   // one access request from the core
   typedef struct packed {
      logic                     is_io;
      logic                     special_io;
      logic                     write;
      logic [`BWSE_ADDR_W-1:0]  addr;
      logic [`BWSE_DATA_W-1:0]  wdata;
   } bwse_req_t;

   // completion report to the core
   typedef struct packed {
      logic                     done;
      logic [`BWSE_DATA_W-1:0]  rdata;
   } bwse_rsp_t;

endpackage

// *** hdl/bwse_wait_sampler.sv ***
`timescale 1ns/100ps
`include "bwse_defines.svh"

module bwse_wait_sampler
   import bwse_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic sample,
   input  wire logic force_hold,
   input  wire logic wait_n,
   output logic      hold_q
);

   // hold decision taken at the rising-half sample point
   always_ff @(posedge clk) begin
      if (srst) begin
         hold_q <= 1'b0;
      end else if (sample) begin
         hold_q <= force_hold | ~wait_n;
      end
   end

endmodule

// *** verification/bwse_slow_dev.sv ***
`timescale 1ns/100ps

// slow memory / peripheral with a saturating counter style wait generator
module bwse_slow_dev
   import bwse_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [15:0] addr,
   input  wire logic        io_sel,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  data_o,
   input  wire logic [2:0]  nwait,
   output logic             wait_n,
   output logic [7:0]       data_i,
   output logic [7:0]       wr_data
);
   logic [3:0] k_q;
   logic [7:0] last_q;
   logic       slow;
   logic       io_sec;

   // memory-mapped io section at 0x8000 and up is the slow part; others never wait
   assign slow = !io_sel && addr[15];
   // io section on select high or on address bit 15 for memory references
   assign io_sec = io_sel || addr[15];
   // wait held low for nwait sample points, two clocks apart
   assign wait_n = !(slow && !(rd_n && wr_n) && (k_q[3:1] < nwait));
   // rom answers on select low below 0x8000, io section otherwise; idle bus holds the complement of the last read data
   assign data_i = rd_n ? ~last_q : (io_sec ? addr[7:0] ^ 8'hc3 : addr[7:0] ^ 8'h5a);

   // counter reloaded each strobe, stepped on the clock
   always_ff @(posedge clk) begin
      if (srst || (rd_n && wr_n)) begin
         k_q <= 4'h0;
      end else if (k_q != 4'hf) begin
         k_q <= k_q + 4'h1;
      end
   end

   // remember driven data and captured writes
   always_ff @(posedge clk) begin
      if (srst) begin
         last_q <= 8'h00;
      end else if (!rd_n) begin
         last_q <= data_i;
      end
      if (!wr_n) begin
         wr_data <= data_o;
      end
   end
endmodule

// *** verification/bwse_bus_cycle_test.sv ***
`timescale 1ns/100ps

module bwse_bus_cycle_test
   import bwse_pkg::*; ;
   logic        clk;
   logic        srst;
   logic        req_valid;
   logic        req_ready;
   bwse_req_t   req;
   bwse_rsp_t   rsp;
   logic [15:0] addr_q;
   logic        io_sel_q;
   logic        rd_n_q;
   logic        wr_n_q;
   logic        wait_n;
   logic [7:0]  data_i;
   logic [7:0]  data_o_q;
   logic        data_oe_q;
   logic [2:0]  nwait;
   logic [7:0]  wr_data;
   int          err_count;
   int          samples_checked;
   int          cyc = 0;

   bwse_bus_cycle uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp(rsp), .addr_q(addr_q), .io_sel_q(io_sel_q), .rd_n_q(rd_n_q),
      .wr_n_q(wr_n_q), .wait_n(wait_n), .data_i(data_i), .data_o_q(data_o_q),
      .data_oe_q(data_oe_q));

   bwse_slow_dev dev (.clk(clk), .srst(srst), .addr(addr_q), .io_sel(io_sel_q), .rd_n(rd_n_q),
      .wr_n(wr_n_q), .data_o(data_o_q), .nwait(nwait), .wait_n(wait_n), .data_i(data_i),
      .wr_data(wr_data));

   // 250 MHz clock
   always #2 clk = ~clk;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one bus cycle: issue, check select, address, length and data
   task automatic run_op(input logic io, input logic sp, input logic wr,
                         input logic [15:0] a, input logic [7:0] wd, input int holds);
      int n;
      req = '{is_io: io, special_io: sp, write: wr, addr: a, wdata: wd};
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
      n = 1;
      check("ready", 16'(req_ready), 16'h0000);
      check("io_sel", 16'(io_sel_q), 16'(io));
      check("addr", addr_q, sp ? {a[7:0], a[7:0]} : a);
      while (rsp.done !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1 n++;
         if (n == 3) begin
            check("rd_n", 16'(rd_n_q), 16'(wr));
            check("wr_n", 16'(wr_n_q), 16'(!wr));
            check("data_oe", 16'(data_oe_q), 16'(wr));
         end
      end
      check("cycles", 16'(n), 16'(7 + 2 * holds));
      check("released", 16'({rd_n_q, wr_n_q, data_oe_q}), 16'h0006);
      if (wr) begin
         check("wdata", 16'(wr_data), 16'(wd));
      end else begin
         check("rdata", 16'(rsp.rdata), 16'(a[7:0] ^ ((io || a[15]) ? 8'hc3 : 8'h5a)));
      end
   endtask

   // slow memory: zero to four waits, back to back
   task t_mem_waits;
      for (int w = 0; w < 5; w++) begin
         nwait = 3'(w);
         run_op(1'b0, 1'b0, 1'b0, 16'h8123 + 16'(w), 8'h00, w);
      end
      nwait = 3'h2;
      run_op(1'b0, 1'b0, 1'b1, 16'h9abc, 8'ha7, 2);
      $display("test mem waits done");
   endtask

   // fast memory is never extended
   task t_fast_mem;
      nwait = 3'h3;
      run_op(1'b0, 1'b0, 1'b0, 16'h0456, 8'h00, 0);
      run_op(1'b0, 1'b0, 1'b1, 16'h07ff, 8'h3c, 0);
      $display("test fast mem done");
   endtask

   // plain io keeps its address and gets no hold
   task t_io;
      run_op(1'b1, 1'b0, 1'b0, 16'h1a05, 8'h00, 0);
      run_op(1'b1, 1'b0, 1'b1, 16'h200e, 8'h91, 0);
      $display("test io done");
   endtask

   // special io gets one automatic hold and a duplicated port
   task t_special;
      run_op(1'b1, 1'b1, 1'b0, 16'hab0e, 8'h00, 1);
      run_op(1'b1, 1'b1, 1'b1, 16'h00e7, 8'h6d, 1);
      $display("test special io done");
   endtask

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      clk = 1'b0;
      srst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      nwait = 3'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      #1 srst = 1'b0;
      check("idle_rd", 16'(rd_n_q), 16'h0001);
      t_mem_waits();
      t_fast_mem();
      t_io();
      t_special();
      final_report();
   end
endmodule
